/* File: hdl/adcc_top.sv */
// Register file, conversion sequencer and result gating for the converter.
// Assumes an AXI4-Lite master and an analog core giving a raw sample on demand.
//
// Local design decisions: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ns
module adcc_top
	import adcc_pkg::*;
#(
	parameter int PIN_COUNT = 16
)(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic hw_trigger,
	input wire logic [15:0] raw_sample,
	input wire logic above_high_ref,
	input wire logic below_low_ref,
	output adcc_analog_s analog_ctrl,
	output logic [PIN_COUNT-1:0] pin_digital_off,
	output logic complete_irq
);

	////////////////////////////////////////////////////////////////////////////
	typedef struct packed {
		logic aw_got;
		logic w_got;
		logic [7:0] aw_addr;
		logic [7:0] w_data;
		logic w_lane;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [7:0] config_r;
		logic [7:0] ctrl2;
		logic [7:0] ctrl3;
		logic [7:0] ctrl1;
		logic complete;
		logic [15:0] result;
		logic [15:0] cmp_val;
		logic [15:0] pins;
		logic hold;
		adcc_state_e state;
		logic [7:0] count;
		logic [2:0] avg_n;
		logic [17:0] acc;
		logic pend;
		logic trig_q;
		adcc_analog_s ana;
		logic irq;
		logic aw_rdy;
		logic w_rdy;
		logic ar_rdy;
	} adcc_state_s;

	adcc_state_s cur_ff;
	adcc_state_s nxt_ff;

	// Full-scale code for the selected width and sense
	function automatic logic [15:0] full_scale(input logic [1:0] m, input logic d);
		logic [15:0] f;
		f = 16'hffff;
		case (m)
			MODE_8: f = d ? 16'h01ff : 16'h00ff;
			MODE_10: f = d ? 16'h07ff : 16'h03ff;
			MODE_12: f = d ? 16'h1fff : 16'h0fff;
			default: f = 16'hffff;
		endcase
		return f;
	endfunction

	function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
		return a == b;
	endfunction

	function automatic logic [7:0] sample_len(input logic long_sel);
		return long_sel ? 8'(SAMPLE_LONG_CYC) : 8'(SAMPLE_SHORT_CYC);
	endfunction

	logic [15:0] fs;
	logic [15:0] sample;
	logic [15:0] avg_val;
	logic cmp_ok;
	logic start_req;
	logic do_write;
	logic do_read;
	logic ctrl1_wr;

	////////////////////////////////////////////////////////////////////////////
	always_comb
	begin
		nxt_ff = cur_ff;
		fs = full_scale(cur_ff.config_r[3:2], cur_ff.ctrl1[BIT_DIFF]);
		// Force full scale or zero on a reference flag, else mask the raw code to the chosen width
		if (above_high_ref)
			sample = fs;
		else if (below_low_ref)
			sample = 16'h0000;
		else
			sample = raw_sample & fs;
		avg_val = cur_ff.acc[17:2];
		do_write = cur_ff.aw_got && cur_ff.w_got && !cur_ff.bvalid;
		do_read = s_axi_arvalid && cur_ff.ar_rdy;
		ctrl1_wr = do_write && cur_ff.w_lane && hit(cur_ff.aw_addr, ADDR_CTRL1);
		start_req = 1'b0;

		// Write channels are accepted independently and joined here
		if (s_axi_awvalid && cur_ff.aw_rdy)
		begin
			nxt_ff.aw_got = 1'b1;
			nxt_ff.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && cur_ff.w_rdy)
		begin
			nxt_ff.w_got = 1'b1;
			nxt_ff.w_data = s_axi_wdata[7:0];
			nxt_ff.w_lane = s_axi_wstrb[0];
		end
		if (cur_ff.bvalid && s_axi_bready)
			nxt_ff.bvalid = 1'b0;
		if (cur_ff.rvalid && s_axi_rready)
			nxt_ff.rvalid = 1'b0;

		if (do_write)
		begin
			nxt_ff.aw_got = 1'b0;
			nxt_ff.w_got = 1'b0;
			nxt_ff.bvalid = 1'b1;
			nxt_ff.bresp = RESP_OKAY;
			if (cur_ff.w_lane)
			begin
				case (cur_ff.aw_addr)
					ADDR_CONFIG: nxt_ff.config_r = cur_ff.w_data;
					ADDR_CTRL2: nxt_ff.ctrl2 = cur_ff.w_data & (CTRL2_WMASK | CTRL2_REFMASK);
					ADDR_CTRL3: nxt_ff.ctrl3 = cur_ff.w_data & CTRL3_WMASK;
					// Abort and restart are applied after the sequencer
					ADDR_CTRL1: nxt_ff.ctrl1 = {1'b0, cur_ff.w_data[6:0]};
					ADDR_CMP_HI: nxt_ff.cmp_val[15:8] = cur_ff.w_data;
					ADDR_CMP_LO: nxt_ff.cmp_val[7:0] = cur_ff.w_data;
					ADDR_PIN1: nxt_ff.pins[7:0] = cur_ff.w_data;
					ADDR_PIN2: nxt_ff.pins[15:8] = cur_ff.w_data;
					ADDR_RES_HI, ADDR_RES_LO: nxt_ff.bresp = RESP_OKAY;
					default: nxt_ff.bresp = RESP_SLVERR;
				endcase
			end
		end

		if (do_read)
		begin
			nxt_ff.rvalid = 1'b1;
			nxt_ff.rresp = RESP_OKAY;
			nxt_ff.rdata = 32'h0;
			case (s_axi_araddr)
				ADDR_CONFIG: nxt_ff.rdata[7:0] = cur_ff.config_r;
				// Bits 3:2 read zero, reference field shows in 1:0
				ADDR_CTRL2: nxt_ff.rdata[7:0] = {cur_ff.state != ST_IDLE,
					cur_ff.ctrl2[6:4], 2'b00, cur_ff.ctrl2[1:0]};
				ADDR_CTRL3: nxt_ff.rdata[7:0] = cur_ff.ctrl3;
				ADDR_CTRL1: nxt_ff.rdata[7:0] = {cur_ff.complete, cur_ff.ctrl1[6:0]};
				ADDR_RES_HI:
				begin
					nxt_ff.rdata[7:0] = cur_ff.result[15:8];
					nxt_ff.hold = 1'b1;
				end
				ADDR_RES_LO:
				begin
					nxt_ff.rdata[7:0] = cur_ff.result[7:0];
					nxt_ff.hold = 1'b0;
					nxt_ff.complete = 1'b0;
				end
				ADDR_CMP_HI: nxt_ff.rdata[7:0] = cur_ff.cmp_val[15:8];
				ADDR_CMP_LO: nxt_ff.rdata[7:0] = cur_ff.cmp_val[7:0];
				ADDR_PIN1: nxt_ff.rdata[7:0] = cur_ff.pins[7:0];
				ADDR_PIN2: nxt_ff.rdata[7:0] = cur_ff.pins[15:8];
				default: nxt_ff.rresp = RESP_SLVERR;
			endcase
		end

		////////////////////////////////////////////////////////////////////////
		nxt_ff.trig_q = hw_trigger;
		if (cur_ff.ctrl2[BIT_HWTRIG] && hw_trigger && !cur_ff.trig_q)
			nxt_ff.pend = 1'b1;
		if (cur_ff.pend && cur_ff.state == ST_IDLE)
			start_req = 1'b1;

		cmp_ok = !cur_ff.ctrl2[BIT_CMPEN]
			|| (cur_ff.ctrl2[BIT_CMPGT] ? (avg_val >= cur_ff.cmp_val)
			: (avg_val < cur_ff.cmp_val));

		case (cur_ff.state)
			ST_IDLE:
			begin
				if (start_req)
				begin
					nxt_ff.pend = 1'b0;
					nxt_ff.state = ST_SAMPLE;
					nxt_ff.count = sample_len(cur_ff.config_r[4]);
				end
			end
			ST_SAMPLE:
			begin
				if (cur_ff.count <= 8'h01)
				begin
					nxt_ff.state = ST_CONVERT;
					nxt_ff.count = 8'(CONV_CYC);
				end
				else
					nxt_ff.count = cur_ff.count - 8'h01;
			end
			ST_CONVERT:
			begin
				if (cur_ff.count <= 8'h01)
				begin
					nxt_ff.acc = cur_ff.acc + {2'b00, sample};
					nxt_ff.avg_n = cur_ff.avg_n + 3'h1;
					nxt_ff.state = ST_DONE;
				end
				else
					nxt_ff.count = cur_ff.count - 8'h01;
			end
			ST_DONE:
			begin
				if (cur_ff.ctrl3[BIT_AVGEN] && cur_ff.avg_n < 3'(AVG_COUNT))
				begin
					// Every averaged sample gets the full sample window
					nxt_ff.state = ST_SAMPLE;
					nxt_ff.count = sample_len(cur_ff.config_r[4]);
				end
				else if (cur_ff.hold)
					nxt_ff.state = ST_DONE;
				else
				begin
					if (!cur_ff.ctrl3[BIT_AVGEN])
						avg_val = cur_ff.acc[15:0];
					cmp_ok = !cur_ff.ctrl2[BIT_CMPEN]
						|| (cur_ff.ctrl2[BIT_CMPGT] ? (avg_val >= cur_ff.cmp_val)
						: (avg_val < cur_ff.cmp_val));
					if (cmp_ok)
					begin
						nxt_ff.result = avg_val;
						nxt_ff.complete = 1'b1;
					end
					nxt_ff.acc = 18'h0;
					nxt_ff.avg_n = 3'h0;
					nxt_ff.state = ST_IDLE;
					if (cur_ff.ctrl1[BIT_CONT] || cur_ff.ctrl3[BIT_C3CONT])
						nxt_ff.pend = 1'b1;
				end
			end
			default: nxt_ff.state = ST_IDLE;
		endcase

		// A ctrl1 write overrides the sequencer and its clear beats a completion;
		// a hardware trigger edge in that same cycle is dropped
		if (ctrl1_wr)
		begin
			nxt_ff.complete = 1'b0;
			nxt_ff.avg_n = 3'h0;
			nxt_ff.acc = 18'h0;
			nxt_ff.state = ST_IDLE;
			nxt_ff.pend = !cur_ff.ctrl2[BIT_HWTRIG];
		end

		nxt_ff.ana.clk_src = cur_ff.config_r[1:0];
		nxt_ff.ana.divide = cur_ff.config_r[6:5];
		nxt_ff.ana.low_power = cur_ff.config_r[BIT_LOWPWR];
		nxt_ff.ana.long_sample = cur_ff.config_r[4];
		nxt_ff.ana.ref_pair = cur_ff.ctrl2[1:0];
		nxt_ff.ana.channel = cur_ff.ctrl1[4:0];
		nxt_ff.ana.diff = cur_ff.ctrl1[BIT_DIFF];
		nxt_ff.ana.sampling = nxt_ff.state == ST_SAMPLE;
		nxt_ff.aw_rdy = !nxt_ff.aw_got;
		nxt_ff.w_rdy = !nxt_ff.w_got;
		nxt_ff.ar_rdy = !nxt_ff.rvalid;
		nxt_ff.irq = nxt_ff.complete && nxt_ff.ctrl1[BIT_IRQEN];
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			cur_ff <= '0;
			cur_ff.config_r <= RST_CONFIG;
			cur_ff.ctrl2 <= RST_CTRL2;
			cur_ff.ctrl3 <= RST_CTRL3;
			cur_ff.ctrl1 <= RST_CTRL1;
			cur_ff.ana.channel <= RST_CTRL1[4:0];
			cur_ff.state <= ST_IDLE;
		end
		else
			cur_ff <= nxt_ff;
	end

	////////////////////////////////////////////////////////////////////////////
	assign s_axi_awready = cur_ff.aw_rdy;
	assign s_axi_wready = cur_ff.w_rdy;
	assign s_axi_bvalid = cur_ff.bvalid;
	assign s_axi_bresp = cur_ff.bresp;
	assign s_axi_arready = cur_ff.ar_rdy;
	assign s_axi_rvalid = cur_ff.rvalid;
	assign s_axi_rdata = cur_ff.rdata;
	assign s_axi_rresp = cur_ff.rresp;
	assign analog_ctrl = cur_ff.ana;
	assign pin_digital_off = PIN_COUNT'(cur_ff.pins);
	assign complete_irq = cur_ff.irq;

	////////////////////////////////////////////////////////////////////////////
	property p_irq_gate;
		@(posedge aclk) disable iff (!aresetn)
		complete_irq |-> $past(cur_ff.ctrl1[BIT_IRQEN]) || cur_ff.ctrl1[BIT_IRQEN];
	endproperty
	a_irq_gate: assert property (p_irq_gate) else $error("irq without enable");

	property p_active_read;
		@(posedge aclk) disable iff (!aresetn)
		(do_read && s_axi_araddr == ADDR_CTRL2) |=> (s_axi_rdata[3:2] == 2'b00
			&& s_axi_rdata[7] == $past(cur_ff.state != ST_IDLE));
	endproperty
	a_active_read: assert property (p_active_read) else $error("ctrl2 readback wrong");

	sequence s_held;
		cur_ff.hold && cur_ff.state == ST_DONE;
	endsequence
	property p_hold;
		@(posedge aclk) disable iff (!aresetn)
		s_held ##0 (cur_ff.avg_n != 3'h0) |=> $stable(cur_ff.result);
	endproperty
	a_hold: assert property (p_hold) else $error("result overwritten while held");

	property p_clamp;
		@(posedge aclk) disable iff (!aresetn)
		(cur_ff.state == ST_CONVERT && cur_ff.count == 8'h01 && above_high_ref
			&& !cur_ff.ctrl3[BIT_AVGEN]) |=> cur_ff.acc[15:0] == $past(fs);
	endproperty
	a_clamp: assert property (p_clamp) else $error("no full-scale clamp");

	property p_swstart;
		@(posedge aclk) disable iff (!aresetn)
		(do_write && cur_ff.w_lane && hit(cur_ff.aw_addr, ADDR_CTRL1)
			&& !cur_ff.ctrl2[BIT_HWTRIG]) |=> ##1 cur_ff.state == ST_SAMPLE;
	endproperty
	a_swstart: assert property (p_swstart) else $error("software start missed");

	property p_cfg_out;
		@(posedge aclk) disable iff (!aresetn)
		##2 analog_ctrl.divide == $past(cur_ff.config_r[6:5])
			&& analog_ctrl.low_power == $past(cur_ff.config_r[7]);
	endproperty
	a_cfg_out: assert property (p_cfg_out) else $error("config not driven");

	property p_cmp_gate;
		@(posedge aclk) disable iff (!aresetn)
		($rose(cur_ff.complete) && cur_ff.ctrl2[BIT_CMPEN] && cur_ff.ctrl2[BIT_CMPGT])
			|-> cur_ff.result >= cur_ff.cmp_val;
	endproperty
	a_cmp_gate: assert property (p_cmp_gate) else $error("flag without compare");

	property p_sample_len;
		@(posedge aclk) disable iff (!aresetn)
		($rose(cur_ff.state == ST_SAMPLE) && !cur_ff.config_r[4])
			|-> (cur_ff.state == ST_SAMPLE) [*4] ##1 cur_ff.state == ST_CONVERT;
	endproperty
	a_sample_len: assert property (p_sample_len) else $error("short sample length");

endmodule // adcc_top

/* File: hdl/adcc_pkg.sv */
// Constants, register map and carrier types for the converter control block.
// Assumes an AXI4-Lite master with 32-bit data and an external SAR core.
package adcc_pkg;
	localparam logic [7:0] ADDR_CONFIG = 8'h00;
	localparam logic [7:0] ADDR_CTRL2 = 8'h04;
	localparam logic [7:0] ADDR_CTRL3 = 8'h08;
	localparam logic [7:0] ADDR_CTRL1 = 8'h0c;
	localparam logic [7:0] ADDR_RES_HI = 8'h10;
	localparam logic [7:0] ADDR_RES_LO = 8'h14;
	localparam logic [7:0] ADDR_CMP_HI = 8'h18;
	localparam logic [7:0] ADDR_CMP_LO = 8'h1c;
	localparam logic [7:0] ADDR_PIN1 = 8'h20;
	localparam logic [7:0] ADDR_PIN2 = 8'h24;
	localparam int BIT_LOWPWR = 7;
	localparam int BIT_ACTIVE = 7;
	localparam int BIT_HWTRIG = 6;
	localparam int BIT_CMPEN = 5;
	localparam int BIT_CMPGT = 4;
	localparam int BIT_COMPLETE = 7;
	localparam int BIT_IRQEN = 6;
	localparam int BIT_CONT = 5;
	localparam int BIT_DIFF = 5;
	localparam int BIT_C3CONT = 3;
	localparam int BIT_AVGEN = 2;
	localparam logic [7:0] RST_CONFIG = 8'h00;
	localparam logic [7:0] RST_CTRL2 = 8'h00;
	localparam logic [7:0] RST_CTRL3 = 8'h00;
	localparam logic [7:0] RST_CTRL1 = 8'h1f;
	localparam logic [7:0] CTRL2_WMASK = 8'h70;
	localparam logic [7:0] CTRL2_REFMASK = 8'h03;
	localparam logic [7:0] CTRL3_WMASK = 8'h0f;
	localparam logic [1:0] MODE_8 = 2'b00;
	localparam logic [1:0] MODE_12 = 2'b01;
	localparam logic [1:0] MODE_10 = 2'b10;
	localparam logic [1:0] MODE_16 = 2'b11;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	localparam int SAMPLE_SHORT_CYC = 4;
	localparam int SAMPLE_LONG_CYC = 24;
	localparam int CONV_CYC = 17;
	localparam int AVG_COUNT = 4;

	typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_CONVERT, ST_DONE} adcc_state_e;

	// Controls handed to the analog core
	typedef struct packed {
		logic [1:0] clk_src;
		logic [1:0] divide;
		logic low_power;
		logic long_sample;
		logic [1:0] ref_pair;
		logic [4:0] channel;
		logic diff;
		logic sampling;
	} adcc_analog_s;
endpackage

/* File: sim/adcc_core_model.sv */
// Behavioural analog core: hands a held code and reference-limit flags to the block.
// Assumes the bench picks the input code and whether it sits beyond a reference.
`timescale 1ns/1ns
module adcc_core_model
	import adcc_pkg::*;
(
	input wire logic aclk,
	input wire adcc_analog_s analog_ctrl,
	input wire logic [15:0] code,
	input wire logic [1:0] level,
	output logic [15:0] raw_sample,
	output logic above_high_ref,
	output logic below_low_ref
);
	logic [15:0] pat_ff = 16'h0000;
	always_ff @(posedge aclk)
	begin
		pat_ff <= pat_ff + 16'h1357;
	end
	// An unselected channel floats, so show a moving pattern rather than a stale code
	assign raw_sample = (analog_ctrl.channel == 5'h1f) ? pat_ff : code;
	assign above_high_ref = (level == 2'd1);
	assign below_low_ref = (level == 2'd2);
endmodule // adcc_core_model

/* File: sim/adc_control_setup_tb.sv */
// Self-checking bench: AXI4-Lite register tasks and conversion scenarios.
// Assumes the analog core model on the far side and a 50 MHz clock.
`timescale 1ns/1ns
module adc_control_setup_tb;
	import adcc_pkg::*;
	logic aclk, aresetn, awv, wv, br, arv, rr, hwt;
	logic [7:0] awa, ara;
	logic [31:0] wd, v;
	logic [1:0] lvl;
	logic [3:0] ws;
	logic [15:0] code;
	adcc_analog_s actl;
	logic [15:0] raw, pins;
	logic ahi, blo, irq, awr, wr_r, bv, arr, rv;
	logic [1:0] brs, rrs;
	logic [31:0] rdat;
	int n_mismatch, checked, cyc;
	logic [15:0] fs [4] = '{16'h00ff, 16'h0fff, 16'h03ff, 16'hffff};

	adcc_top uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
		.s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
		.s_axi_wready(wr_r), .s_axi_bresp(brs), .s_axi_bvalid(bv), .s_axi_bready(br),
		.s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
		.s_axi_rresp(rrs), .s_axi_rvalid(rv), .s_axi_rready(rr), .hw_trigger(hwt),
		.raw_sample(raw), .above_high_ref(ahi), .below_low_ref(blo), .analog_ctrl(actl),
		.pin_digital_off(pins), .complete_irq(irq));
	adcc_core_model u_core (.aclk(aclk), .analog_ctrl(actl), .code(code), .level(lvl),
		.raw_sample(raw), .above_high_ref(ahi), .below_low_ref(blo));

	////////////////////////////////////////////////////////////////////////////////
	task chkv(input logic [31:0] got, input logic [31:0] exp, input string m);
		checked++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask

	task chkr(input logic [1:0] got, input logic [1:0] exp);
		checked++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("[FAIL] %0t response got %h exp %h", $time, got, exp);
		end
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge aclk);
		awa <= a;
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		br <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (awr)
				awv <= 1'b0;
			if (wr_r)
				wv <= 1'b0;
		end
		while (!bv);
		br <= 1'b0;
		chkr(brs, er);
	endtask

	task rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
		@(posedge aclk);
		ara <= a;
		arv <= 1'b1;
		rr <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (arr)
				arv <= 1'b0;
		end
		while (!rv);
		rr <= 1'b0;
		d = rdat;
		chkr(rrs, er);
	endtask

	task rdc(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] d;
		rd(a, d, RESP_OKAY);
		chkv(d, exp, "read");
	endtask

	// Polls rather than waiting a fixed time, so sample length changes do not matter
	task poll;
		logic [31:0] d;
		for (int i = 0; i < 60; i++)
		begin
			rd(ADDR_CTRL1, d, RESP_OKAY);
			if (d[BIT_COMPLETE] === 1'b1)
				break;
		end
	endtask

	task conv(input logic [7:0] cfg, input logic [1:0] l, input logic [15:0] exp);
		lvl <= l;
		wr(ADDR_CONFIG, {24'h0, cfg}, RESP_OKAY);
		wr(ADDR_CTRL1, 32'h01, RESP_OKAY);
		poll();
		rdc(ADDR_RES_HI, {24'h0, exp[15:8]});
		rdc(ADDR_RES_LO, {24'h0, exp[7:0]});
	endtask

	task complete_run;
		$display("checks %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		aclk = 1'b0;
		forever #10 aclk = ~aclk;
	end

	always @(posedge aclk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			n_mismatch++;
			complete_run();
		end
	end

	initial
	begin
		{aresetn, awv, wv, br, arv, rr, hwt} = '0;
		{awa, ara, wd, lvl} = '0;
		ws = 4'hf;
		code = 16'h1abc;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		rdc(ADDR_CONFIG, 32'h00);
		rdc(ADDR_CTRL2, 32'h00);
		rdc(ADDR_CTRL1, 32'h1f);
		chkv({27'h0, actl.channel}, 32'h1f, "reset channel");
		chkv({31'h0, irq}, 32'h0, "reset irq");
		rd(8'h40, v, RESP_SLVERR);
		wr(8'h40, 32'h0, RESP_SLVERR);
		wr(ADDR_CTRL2, 32'h3e, RESP_OKAY);
		rdc(ADDR_CTRL2, 32'h32);
		chkv({30'h0, actl.ref_pair}, 32'h2, "ref pair");
		wr(ADDR_CTRL2, 32'h00, RESP_OKAY);
		$display("test registers done");
		wr(ADDR_CONFIG, 32'h98, RESP_OKAY);
		repeat (2) @(posedge aclk);
		chkv({30'h0, actl.low_power, actl.long_sample}, 32'h3, "power/sample");
		chkv({28'h0, actl.divide, actl.clk_src}, 32'h0, "divide/source");
		ws <= 4'he;
		wr(ADDR_CONFIG, 32'h55, RESP_OKAY);
		ws <= 4'hf;
		rdc(ADDR_CONFIG, 32'h98);
		wr(ADDR_CTRL1, 32'h41, RESP_OKAY);
		rdc(ADDR_CTRL2, 32'h80);
		chkv({31'h0, actl.sampling}, 32'h1, "sampling");
		poll();
		chkv({31'h0, irq}, 32'h1, "irq on");
		chkv({27'h0, actl.channel}, 32'h1, "channel");
		rdc(ADDR_CTRL1, 32'hc1);
		rdc(ADDR_RES_HI, 32'h02);
		rdc(ADDR_RES_LO, 32'hbc);
		rdc(ADDR_CTRL1, 32'h41);
		chkv({31'h0, irq}, 32'h0, "irq off");
		repeat (60) @(posedge aclk);
		rdc(ADDR_CTRL1, 32'h41);
		$display("test single conversion done");
		for (int m = 0; m < 4; m++)
		begin
			conv({4'h0, m[1:0], 2'b00}, 2'd1, fs[m]);
			conv({4'h0, m[1:0], 2'b00}, 2'd2, 16'h0000);
		end
		lvl <= 2'd0;
		$display("test clamping done");
		wr(ADDR_PIN1, 32'h02, RESP_OKAY);
		repeat (2) @(posedge aclk);
		chkv({16'h0, pins}, 32'h0002, "pin gating");
		wr(ADDR_CTRL3, 32'h04, RESP_OKAY);
		rdc(ADDR_CTRL3, 32'h04);
		conv(8'h08, 2'd0, 16'h02bc);
		wr(ADDR_CTRL3, 32'h08, RESP_OKAY);
		conv(8'h08, 2'd0, 16'h02bc);
		poll();
		rdc(ADDR_CTRL1, 32'h81);
		wr(ADDR_CTRL3, 32'h00, RESP_OKAY);
		repeat (60) @(posedge aclk);
		$display("test averaging and continuous done");
		wr(ADDR_CONFIG, 32'h08, RESP_OKAY);
		wr(ADDR_CMP_HI, 32'h03, RESP_OKAY);
		wr(ADDR_CMP_LO, 32'hff, RESP_OKAY);
		wr(ADDR_CTRL2, 32'h30, RESP_OKAY);
		code <= 16'h03ff;
		wr(ADDR_CTRL1, 32'h01, RESP_OKAY);
		poll();
		rdc(ADDR_CTRL1, 32'h81);
		rdc(ADDR_RES_HI, 32'h03);
		rdc(ADDR_RES_LO, 32'hff);
		code <= 16'h0100;
		wr(ADDR_CTRL1, 32'h01, RESP_OKAY);
		repeat (60) @(posedge aclk);
		rdc(ADDR_CTRL1, 32'h01);
		$display("test compare done");
		wr(ADDR_CTRL2, 32'h40, RESP_OKAY);
		wr(ADDR_CTRL1, 32'h01, RESP_OKAY);
		repeat (60) @(posedge aclk);
		rdc(ADDR_CTRL1, 32'h01);
		hwt <= 1'b1;
		poll();
		hwt <= 1'b0;
		rdc(ADDR_CTRL1, 32'h81);
		rdc(ADDR_RES_HI, 32'h01);
		rdc(ADDR_RES_LO, 32'h00);
		$display("test hardware trigger done");
		complete_run();
	end
endmodule // adc_control_setup_tb
